// ---- include/ohpc_pkg.sv ----
// Package for the overhead parameter message codec: opcodes, field layout, register map
package ohpc_pkg;

    // Message opcodes
    localparam logic [7:0] OP_FREQ     = 8'h16;
    localparam logic [7:0] OP_FREP     = 8'h17;
    localparam logic [7:0] OP_OINFO    = 8'h1E;
    localparam logic [7:0] OP_RINFO    = 8'h1F;
    localparam logic [7:0] OP_INTERLEAVE_DEPTH_SELECT  = 8'h21;
    localparam logic [7:0] OP_FRAME    = 8'h22;
    localparam logic [7:0] OP_MASK     = 8'h23;
    localparam logic [7:0] OP_LEVEL    = 8'h24;
    localparam logic [7:0] OP_LEVREP   = 8'h25;
    localparam logic [7:0] OP_BAUD     = 8'h26;
    localparam logic [7:0] OP_EXCBW    = 8'h29;
    localparam logic [7:0] OP_RB_OFFS  = 8'h20;
    localparam logic [7:0] OP_RB_LO    = 8'h40;
    localparam logic [7:0] OP_RB_HI    = 8'h5F;
    localparam logic [7:0] OP_RSV_LO   = 8'h18;
    localparam logic [7:0] OP_RSV_HI   = 8'h1D;
    localparam logic [7:0] OP_PROP_LO  = 8'h90;
    localparam logic [7:0] OP_PROP_HI  = 8'h9F;

    // Data word layout and codes
    localparam int         SET_MSB     = 15;
    localparam int         SET_LSB     = 14;
    localparam int         DIR_BIT     = 13;
    localparam int         CAR_BIT     = 12;
    localparam logic [1:0] SET_INIT    = 2'h0;
    localparam logic [1:0] SET_SECOND  = 2'h1;
    localparam logic [1:0] SET_CUR     = 2'h2;
    localparam logic [1:0] SET_REC     = 2'h3;
    localparam logic [7:0] F_MAX       = 8'hB4;
    localparam logic [3:0] RFH_MAX     = 4'h8;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;

    // Parameter kinds held in the activation database
    localparam int         NUM_KIND    = 7;
    localparam int         NUM_SET     = 3;
    localparam int         NUM_CAR     = 4;
    localparam int         DB_DEPTH    = NUM_KIND * NUM_SET * NUM_CAR;
    localparam logic [2:0] KIND_NONE   = 3'h7;
    localparam int         INFO_WORDS  = 6;

    // APB register byte offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_FCNT    = 8'h04;
    localparam logic [7:0] REG_OCNT    = 8'h08;
    localparam logic [7:0] REG_DBSEL   = 8'h0C;
    localparam logic [7:0] REG_DBDATA  = 8'h10;
    localparam logic [7:0] REG_RINFO0  = 8'h14;
    localparam logic [7:0] REG_RINFO1  = 8'h18;
    localparam logic [7:0] REG_RINFO2  = 8'h1C;
    localparam logic [7:0] REG_OINFO0  = 8'h20;
    localparam logic [7:0] REG_OINFO1  = 8'h24;
    localparam logic [7:0] REG_OINFO2  = 8'h28;
    localparam logic [7:0] REG_DISC    = 8'h2C;
    localparam logic [2:0] CTRL_RST    = 3'h0;
    localparam int         CTRL_FAST   = 0;
    localparam int         CTRL_EXCBW  = 1;
    localparam int         CTRL_LEVREP = 2;

    typedef struct packed {
        logic        cont;
        logic [7:0]  opcode;
        logic [15:0] data;
    } ohpc_msg_t;

    typedef enum logic [1:0] {CM_IDLE, CM_RINFO, CM_OINFO} ohpc_cmode_t;

endpackage

// ---- hdl/ohpc_codec.sv ----
// Remote-end overhead channel parameter message codec with APB register access
// Summary of operation
// - Opcode 0x16 read with zero data echoes fast uncorrectable count since last request
// - Opcode 0x17 office write carries its fast count in command and echo
// - Reported 16-bit error counters saturate at maximum, never wrap
// - Fast count request is served only when fast channel support is enabled
// - Info payload is 12 octets: vendor, revision, spectrum, convergence, baud
// - Info words after the first move by continuation-word commands
// - Office and remote info payloads share one identical octet format
// - Parameter writes only store into the activation database, not the link
// - Stored values apply only after a separate trigger procedure
// - Parameter writes are write type; echo equals command data
// - Data word: set code 15..14, direction 13, carrier 12, value 11..0
// - Set code 00 initial, 01 second, 10 current
// - Set code 11 recommended-current, legal only in read-back
// - Bits 13..12 carry the carrier code of the monitoring messages
// - Carrier code 00 down 1, 01 down 2, 10 up 1, 11 up 2
// - Both-carrier messages send bit 12 as 0; receiver ignores it
// - Optional read-back verifies a parameter or fetches recommended value
// - Read-back opcode is setting opcode plus 0x20, range 0x40 to 0x5F
// - Read-back command has zero value; echo returns stored value in 11..0
// - Opcode 0x21 interleave depth: ratio code high bits, M in low 8
// - Opcode 0x22 codeword layout: F in upper 8, half redundancy low 4
// - Fast codeword F at most 180, redundancy at most 16
// - Opcode 0x23 carries a 12-bit regional spectral mask code
// - Opcode 0x26 baud profile: upper 2 bits zero, 10-bit profile number
// - All mandatory settings supported; excess bandwidth and level report optional
// - Opcodes 0x90-0x9F proprietary and 0x18-0x1D reserved
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module ohpc_codec
    import ohpc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fast_err_evt,
    input  wire logic        cmd_valid,
    input  wire ohpc_msg_t   cmd_msg,
    output logic             echo_valid,
    output ohpc_msg_t        echo_msg,
    output logic             discard
);

    function automatic logic [2:0] kind_of(input logic [7:0] op);
        case (op)
            OP_INTERLEAVE_DEPTH_SELECT: kind_of = 3'd0;
            OP_FRAME:   kind_of = 3'd1;
            OP_MASK:    kind_of = 3'd2;
            OP_LEVEL:   kind_of = 3'd3;
            OP_LEVREP:  kind_of = 3'd4;
            OP_BAUD:    kind_of = 3'd5;
            OP_EXCBW:   kind_of = 3'd6;
            default:    kind_of = KIND_NONE;
        endcase
    endfunction

    // Value bits that must be zero per kind
    function automatic logic [11:0] zmask(input logic [2:0] k);
        case (k)
            3'd3, 3'd4: zmask = 12'h0F00;
            3'd5:       zmask = 12'h0C00;
            3'd6:       zmask = 12'h0FFC;
            default:    zmask = 12'h0000;
        endcase
    endfunction

    function automatic logic [6:0] db_index(input logic [2:0] k, input logic [1:0] s,
                                            input logic [1:0] c);
        db_index = 7'(int'(k) * NUM_SET * NUM_CAR + int'(s) * NUM_CAR + int'(c));
    endfunction

    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == CNT_MAX) ? v : v + 16'h0001;
    endfunction

    logic [2:0]   ctrl_q;
    logic [15:0]  fcnt_q;
    logic [15:0]  fcnt_d;
    logic [15:0]  ocnt_q;
    logic [15:0]  disc_q;
    logic [6:0]   dbsel_q;
    logic [31:0]  rinfo_q [3];
    logic [15:0]  oinfo_q [INFO_WORDS];
    logic [11:0]  db_q [DB_DEPTH];
    logic [2:0]   ptr_q;
    ohpc_cmode_t  cmode_q;
    ohpc_cmode_t  cmode_d;
    logic [31:0]  prdata_q;
    logic         pslverr_q;
    logic         echo_valid_q;
    ohpc_msg_t    echo_msg_q;
    logic         discard_q;

    // Command decode
    wire        is_cont  = cmd_msg.cont;
    wire [7:0]  op       = cmd_msg.opcode;
    wire [15:0] dw       = cmd_msg.data;
    wire [1:0]  set_c    = dw[SET_MSB:SET_LSB];
    wire        is_rb    = (op >= OP_RB_LO) && (op <= OP_RB_HI);
    wire [7:0]  base_op  = is_rb ? op - OP_RB_OFFS : op;
    wire [2:0]  kind     = kind_of(base_op);
    wire        kind_sup = (kind != KIND_NONE)
                         && (kind != 3'd6 || ctrl_q[CTRL_EXCBW])
                         && (kind != 3'd4 || ctrl_q[CTRL_LEVREP]);
    // Both-carrier kinds drop bit 12, per-set kinds drop the carrier entirely
    wire [1:0]  car_n    = (kind == 3'd0 || kind == 3'd1) ? {dw[DIR_BIT], 1'b0}
                         : (kind == 3'd2 || kind == 3'd6) ? 2'b00
                         : dw[DIR_BIT:CAR_BIT];
    wire        frame_ok = (kind != 3'd1)
                         || (dw[11:4] <= F_MAX && dw[3:0] <= RFH_MAX);
    wire        wr_ok    = !is_rb && kind_sup && set_c != SET_REC
                         && (dw[11:0] & zmask(kind)) == 12'h000 && frame_ok;
    wire        rb_ok    = is_rb && kind_sup && dw[11:0] == 12'h000;
    // Recommended current value is the stored current value
    wire [1:0]  set_eff  = (set_c == SET_REC) ? SET_CUR : set_c;
    wire [6:0]  idx      = db_index(kind, set_eff, car_n);

    wire        m_freq   = !is_cont && op == OP_FREQ && ctrl_q[CTRL_FAST]
                         && dw == 16'h0000;
    wire        m_frep   = !is_cont && op == OP_FREP;
    wire        m_rinfo  = !is_cont && op == OP_RINFO && dw == 16'h0000;
    wire        m_oinfo  = !is_cont && op == OP_OINFO;
    wire        m_cont_r = is_cont && cmode_q == CM_RINFO;
    wire        m_cont_o = is_cont && cmode_q == CM_OINFO;
    wire        m_wr     = !is_cont && wr_ok;
    wire        m_rb     = !is_cont && rb_ok;
    wire        accept   = m_freq | m_frep | m_rinfo | m_oinfo | m_cont_r
                         | m_cont_o | m_wr | m_rb;
    wire        take     = cmd_valid && accept;
    wire        reject   = cmd_valid && !accept;

    // Remote info words, first octet on the high byte
    wire [95:0] rinfo_flat = {rinfo_q[0], rinfo_q[1], rinfo_q[2]};
    wire [2:0]  rword_sel  = m_rinfo ? 3'd0 : ptr_q;
    wire [15:0] rword      = rinfo_flat[(3'd5 - rword_sel) * 16 +: 16];
    wire [15:0] echo_data  = m_freq ? fcnt_q
                           : (m_rinfo || m_cont_r) ? rword
                           : m_rb ? {dw[15:12], db_q[idx]}
                           : dw;

    // Continuation tracking
    wire        info_start = take && (m_rinfo || m_oinfo);
    wire        info_step  = take && (m_cont_r || m_cont_o);
    wire        info_last  = ptr_q == 3'(INFO_WORDS - 1);
    always_comb begin
        cmode_d = cmode_q;
        if (info_start) begin
            cmode_d = m_rinfo ? CM_RINFO : CM_OINFO;
        end else if (info_step && info_last) begin
            cmode_d = CM_IDLE;
        end else if (take && !is_cont) begin
            cmode_d = CM_IDLE;
        end
        case (cmode_d)
            CM_IDLE, CM_RINFO, CM_OINFO: ;
            default: cmode_d = CM_IDLE;
        endcase
    end

    // Request clears the count; an event in the same cycle still counts
    wire [15:0] fcnt_base = (take && m_freq) ? 16'h0000 : fcnt_q;
    assign fcnt_d = fast_err_evt ? sat_inc(fcnt_base) : fcnt_base;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmode_q <= CM_IDLE;
            ptr_q   <= 3'd0;
        end else begin
            cmode_q <= cmode_d;
            if (info_start) begin
                ptr_q <= 3'd1;
            end else if (info_step) begin
                ptr_q <= ptr_q + 3'd1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fcnt_q <= 16'h0000;
            ocnt_q <= 16'h0000;
            disc_q <= 16'h0000;
        end else begin
            fcnt_q <= fcnt_d;
            if (take && m_frep) begin
                ocnt_q <= dw;
            end
            if (reject) begin
                disc_q <= sat_inc(disc_q);
            end
        end
    end

    // Office info store, same word layout as remote info
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < INFO_WORDS; i++) begin
                oinfo_q[i] <= 16'h0000;
            end
        end else if (take && m_oinfo) begin
            oinfo_q[0] <= dw;
        end else if (take && m_cont_o) begin
            oinfo_q[ptr_q] <= dw;
        end
    end

    // Activation database; the running link reads it only through a trigger
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < DB_DEPTH; i++) begin
                db_q[i] <= 12'h000;
            end
        end else if (take && m_wr) begin
            db_q[idx] <= dw[11:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            echo_valid_q <= 1'b0;
            echo_msg_q   <= '0;
            discard_q    <= 1'b0;
        end else begin
            echo_valid_q <= take;
            discard_q    <= reject;
            if (take) begin
                echo_msg_q <= '{cont: is_cont, opcode: op, data: echo_data};
            end
        end
    end

    assign echo_valid = echo_valid_q;
    assign echo_msg   = echo_msg_q;
    assign discard    = discard_q;

    // APB slave, zero wait states; read data latched in the setup cycle
    wire        apb_setup = psel && !penable;
    wire        apb_wr    = psel && penable && pwrite;
    wire [2:0]  sel_kind  = dbsel_q[6:4];
    // Select field is packed, the store is dense: map through the same index
    wire [1:0]  sel_set   = (dbsel_q[3:2] == SET_REC) ? SET_CUR : dbsel_q[3:2];
    wire [6:0]  sel_idx   = db_index(sel_kind, sel_set, dbsel_q[1:0]);
    wire [11:0] dbdata    = (sel_kind < 3'(NUM_KIND)) ? db_q[sel_idx] : 12'h000;
    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            REG_CTRL:   rd_mux = {29'h0, ctrl_q};
            REG_FCNT:   rd_mux = {16'h0000, fcnt_q};
            REG_OCNT:   rd_mux = {16'h0000, ocnt_q};
            REG_DBSEL:  rd_mux = {25'h0, dbsel_q};
            REG_DBDATA: rd_mux = {20'h0_0000, dbdata};
            REG_RINFO0: rd_mux = rinfo_q[0];
            REG_RINFO1: rd_mux = rinfo_q[1];
            REG_RINFO2: rd_mux = rinfo_q[2];
            REG_OINFO0: rd_mux = {oinfo_q[0], oinfo_q[1]};
            REG_OINFO1: rd_mux = {oinfo_q[2], oinfo_q[3]};
            REG_OINFO2: rd_mux = {oinfo_q[4], oinfo_q[5]};
            REG_DISC:   rd_mux = {16'h0000, disc_q};
            default:    rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (apb_setup) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_q <= !rd_hit;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q  <= CTRL_RST;
            dbsel_q <= 7'h00;
            for (int i = 0; i < 3; i++) begin
                rinfo_q[i] <= 32'h0000_0000;
            end
        end else if (apb_wr) begin
            case (paddr)
                REG_CTRL:   ctrl_q     <= pwdata[2:0];
                REG_DBSEL:  dbsel_q    <= pwdata[6:0];
                REG_RINFO0: rinfo_q[0] <= pwdata;
                REG_RINFO1: rinfo_q[1] <= pwdata;
                REG_RINFO2: rinfo_q[2] <= pwdata;
                default: ;
            endcase
        end
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = pslverr_q && psel && penable;

    // Checks
    wire rsv_op = (op >= OP_RSV_LO && op <= OP_RSV_HI) || (op >= OP_PROP_LO && op <= OP_PROP_HI);

    sat_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        fcnt_q == CNT_MAX && !(take && m_freq) |=> fcnt_q == CNT_MAX)
        else $error("fast count wrapped");
    freq_echo_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        take && m_freq |=> echo_valid && echo_msg.data == $past(fcnt_q)
            && echo_msg.opcode == OP_FREQ)
        else $error("count request echo wrong");
    frep_store_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        take && m_frep |=> ocnt_q == $past(dw) && echo_msg.data == ocnt_q)
        else $error("office count report not stored");
    no_fast_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_valid && !is_cont && op == OP_FREQ && !ctrl_q[CTRL_FAST] |=> discard && !echo_valid)
        else $error("count request served without fast channel");
    wr_echo_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        take && m_wr |=> echo_valid && echo_msg.data == $past(dw)
            && echo_msg.opcode == $past(op))
        else $error("write echo differs");
    rec_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_valid && !is_cont && !is_rb && kind != KIND_NONE && set_c == SET_REC |=> discard)
        else $error("write with recommended set code taken");
    rb_value_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        take && m_wr ##1 !(take && m_wr) ##1 take && m_rb && idx == $past(idx, 2) |=>
            echo_msg.data[11:0] == $past(dw[11:0], 3))
        else $error("read-back value differs from stored");
    rsv_drop_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_valid && !is_cont && rsv_op |=> discard && !echo_valid)
        else $error("reserved opcode not discarded");
    frame_lim_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_valid && !is_cont && op == OP_FRAME && dw[11:4] > F_MAX |=> discard)
        else $error("codeword layout over limit taken");

    info_walk_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        take && m_cont_r && info_last);
    freq_sat_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        take && m_freq && fcnt_q == CNT_MAX);
    rb_rec_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        take && m_rb && set_c == SET_REC);

endmodule // ohpc_codec

// ---- bench/ohpc_office_model.sv ----
// Office-side command channel model driving the codec command port
`timescale 1ns/100ps
module ohpc_office_model
    import ohpc_pkg::*;
(
    input  wire logic      core_clk,
    output logic           cmd_valid,
    output ohpc_msg_t      cmd_msg,
    input  wire logic      echo_valid,
    input  wire ohpc_msg_t echo_msg,
    input  wire logic      discard
);
    initial begin
        cmd_valid = 1'b0;
        cmd_msg   = '0;
    end

    // One word a call; idle word is inverted so stale data never matches
    task automatic xfer(input logic c, input logic [7:0] op, input logic [15:0] d,
                        output logic ev, output logic dv, output ohpc_msg_t em);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_msg   <= '{cont: c, opcode: op, data: d};
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        cmd_msg   <= ~cmd_msg;
        #1;
        ev = echo_valid;
        dv = discard;
        em = echo_msg;
    endtask
endmodule // ohpc_office_model

// ---- bench/ohpc_codec_bench.sv ----
// Self-checking bench for the overhead parameter message codec
`timescale 1ns/100ps
module ohpc_codec_bench
    import ohpc_pkg::*;
;
    logic        core_clk;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fast_err_evt;
    logic        cmd_valid;
    ohpc_msg_t   cmd_msg;
    logic        echo_valid;
    ohpc_msg_t   echo_msg;
    logic        discard;
    int          fails;
    int          checks_done;
    logic [31:0] rd;
    logic        er;
    logic [7:0]  bad_op [6] = '{8'h18, 8'h1D, 8'h90, 8'h9F, 8'h27, 8'h40};

    ohpc_codec dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fast_err_evt(fast_err_evt), .cmd_valid(cmd_valid),
        .cmd_msg(cmd_msg), .echo_valid(echo_valid), .echo_msg(echo_msg), .discard(discard));

    ohpc_office_model ofc (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_msg(cmd_msg),
        .echo_valid(echo_valid), .echo_msg(echo_msg), .discard(discard));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic print_verdict();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Master holds the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Expect either an echo with given data or a discard
    task automatic cmd(input logic c, input logic [7:0] op, input logic [15:0] d,
                       input logic exp_e, input logic [15:0] exp_d);
        logic        ev;
        logic        dv;
        ohpc_msg_t   em;
        ofc.xfer(c, op, d, ev, dv, em);
        cmp_val({30'h0, ev, dv}, {30'h0, exp_e, ~exp_e});
        if (exp_e) begin
            cmp_val({16'h0000, em.data}, {16'h0000, exp_d});
            cmp_val({23'h0, em.cont, em.opcode}, {23'h0, c, op});
        end
    endtask

    initial begin
        // Roughly 90k cycles, well past the saturation run
        #450_000;
        fails++;
        print_verdict();
    end

    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        fast_err_evt = 1'b0;
        fails = 0;
        checks_done = 0;
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0000_0000);
        cmp_val(rd, 32'h0000_0000);
        apb(1'b0, 8'h30, 32'h0000_0000);
        cmp_val({31'h0, er}, 32'h0000_0001);
        cmd(1'b0, OP_FREQ, 16'h0000, 1'b0, 16'h0000);
        cmd(1'b0, OP_EXCBW, 16'h0002, 1'b0, 16'h0000);
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        cmd(1'b0, OP_FREQ, 16'h0000, 1'b1, 16'h0000);
        @(posedge core_clk);
        fast_err_evt <= 1'b1;
        repeat (3) @(posedge core_clk);
        fast_err_evt <= 1'b0;
        cmd(1'b0, OP_FREQ, 16'h0000, 1'b1, 16'h0003);
        cmd(1'b0, OP_FREQ, 16'h0001, 1'b0, 16'h0000);
        @(posedge core_clk);
        fast_err_evt <= 1'b1;
        // Long enough to pass the 16-bit ceiling
        repeat (65540) @(posedge core_clk);
        fast_err_evt <= 1'b0;
        cmd(1'b0, OP_FREQ, 16'h0000, 1'b1, 16'hFFFF);
        cmd(1'b0, OP_FREP, 16'h1234, 1'b1, 16'h1234);
        apb(1'b0, REG_OCNT, 32'h0000_0000);
        cmp_val(rd, 32'h0000_1234);
        cmd(1'b0, OP_INTERLEAVE_DEPTH_SELECT, 16'h8123, 1'b1, 16'h8123);
        cmd(1'b0, 8'h41, 16'h8000, 1'b1, 16'h8123);
        apb(1'b1, REG_DBSEL, 32'h0000_0008);
        apb(1'b0, REG_DBDATA, 32'h0000_0000);
        cmp_val(rd, 32'h0000_0123);
        for (int s = 0; s < 3; s++)
            cmd(1'b0, OP_BAUD, {2'(s), 2'b01, 12'h010 + 12'(s)}, 1'b1,
                {2'(s), 2'b01, 12'h010 + 12'(s)});
        for (int s = 0; s < 3; s++)
            cmd(1'b0, 8'h46, {2'(s), 2'b01, 12'h000}, 1'b1,
                {2'(s), 2'b01, 12'h010 + 12'(s)});
        cmd(1'b0, OP_BAUD, 16'hD005, 1'b0, 16'h0000);
        cmd(1'b0, 8'h46, 16'hD000, 1'b1, 16'hD012);
        cmd(1'b0, OP_BAUD, 16'h0400, 1'b0, 16'h0000);
        cmd(1'b0, OP_FRAME, 16'h3403, 1'b1, 16'h3403);
        cmd(1'b0, 8'h42, 16'h2000, 1'b1, 16'h2403);
        cmd(1'b0, OP_FRAME, 16'h0B51, 1'b0, 16'h0000);
        cmd(1'b0, OP_FRAME, 16'h0B48, 1'b1, 16'h0B48);
        cmd(1'b0, OP_FRAME, 16'h0B49, 1'b0, 16'h0000);
        cmd(1'b0, OP_MASK, 16'h8ABC, 1'b1, 16'h8ABC);
        cmd(1'b0, OP_LEVEL, 16'h0100, 1'b0, 16'h0000);
        cmd(1'b0, OP_LEVREP, 16'h0064, 1'b0, 16'h0000);
        apb(1'b1, REG_CTRL, 32'h0000_0003);
        cmd(1'b0, OP_EXCBW, 16'h0002, 1'b1, 16'h0002);
        cmd(1'b0, OP_EXCBW, 16'h0004, 1'b0, 16'h0000);
        foreach (bad_op[i])
            cmd(1'b0, bad_op[i], 16'h8001, 1'b0, 16'h0000);
        cmd(1'b0, 8'h41, 16'h8000, 1'b1, 16'h8123);
        apb(1'b1, REG_RINFO0, 32'h0102_0304);
        apb(1'b1, REG_RINFO1, 32'h0506_0708);
        apb(1'b1, REG_RINFO2, 32'h090A_0B0C);
        cmd(1'b0, OP_RINFO, 16'h0000, 1'b1, 16'h0102);
        for (int i = 1; i < 6; i++)
            cmd(1'b1, 8'h00, 16'h0000, 1'b1, {8'(2 * i + 1), 8'(2 * i + 2)});
        cmd(1'b1, 8'h00, 16'h0000, 1'b0, 16'h0000);
        for (int i = 0; i < 6; i++)
            cmd(i != 0, OP_OINFO, 16'hA000 + 16'(i), 1'b1, 16'hA000 + 16'(i));
        apb(1'b0, REG_OINFO0, 32'h0000_0000);
        cmp_val(rd, 32'hA000_A001);
        apb(1'b0, REG_OINFO2, 32'h0000_0000);
        cmp_val(rd, 32'hA004_A005);
        print_verdict();
    end
endmodule // ohpc_codec_bench
